/* dv/eie_exec_tb.sv */
// self-checking bench of the extended instruction executor
`timescale 1ns/1ns
module eie_exec_tb;
  logic        clk, rst_n, awv, wv, bry, arv, rry, iv, acc; // handshakes and operand flags
  logic [7:0]  awa, ara, working_register, lath, fop, mrd;               // bus addresses and byte inputs
  logic [31:0] wd, got, seed;                                 // write data, read data, xorshift state
  logic [15:0] iw;                                            // instruction word
  logic [11:0] p0, p1, fp;                                    // pointer values
  logic [20:0] pc, return_stack_top;                                       // program counter and stack top
  logic [4:0]  latu;                                          // upper latch
  logic [3:0]  bank_select_register;                                           // bank select
  logic [1:0]  resp, s;                                       // last response, pointer select
  logic [5:0]  k;                                             // pointer literal
  wire         awr, wr, bv, arr, rv, pwe, pld, spu, spo, mwe, hit, una;
  wire  [1:0]  br, rr, psel;
  wire  [31:0] rd;
  wire  [11:0] pwd, mra, mwa, fad;
  wire  [20:0] pcw, spd;
  wire  [7:0]  mwd;
  int          error_cnt, samples_checked;

  eie_exec dut (.clock_in(clk), .resetn_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .instr_valid_in(iv),
    .instr_word_in(iw), .ptr0_in(p0), .ptr1_in(p1), .frame_pointer_in(fp), .working_register_in(working_register),
    .pc_in(pc), .pc_high_latch_in(lath), .pc_upper_latch_in(latu), .return_stack_top_in(return_stack_top),
    .bank_select_register_in(bank_select_register), .file_operand_in(fop), .access_bit_in(acc), .mem_rdata_in(mrd),
    .ptr_we_out(pwe), .ptr_sel_out(psel), .ptr_wdata_out(pwd), .pc_load_out(pld), .pc_wdata_out(pcw),
    .stack_push_out(spu), .stack_push_data_out(spd), .stack_pop_out(spo), .mem_raddr_out(mra),
    .mem_we_out(mwe), .mem_waddr_out(mwa), .mem_wdata_out(mwd), .file_addr_out(fad),
    .ext_hit_out(hit), .unassigned_out(una));

  ////////////////////////////////////////////////////////////////////////////
  // helpers: random source, expectation, compare
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // new pointer value after an add or subtract
  function automatic logic [11:0] pexp(input logic [1:0] sl, input logic [5:0] kk, input logic sb);
    logic [11:0] b;
    b = (sl == 2'h0) ? p0 : (sl == 2'h1) ? p1 : fp;
    return sb ? b - {6'h00, kk} : b + {6'h00, kk};
  endfunction : pexp
  // wide enough for the longest packed group of outputs compared at once
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////
  // bus master: address and data offered together, wait for each answer
  // no local limit: only the watchdog ends a wait that is never answered
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do @(posedge clk); while (!(awr === 1'b1 && wr === 1'b1));
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    resp = br;
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    got = rd; resp = rr;
    rry <= 1'b0;
  endtask : axr
  // one instruction word with fresh random core state; outputs settle after the taking edge
  task automatic op(input logic [15:0] w, input logic [11:0] f);
    @(posedge clk);
    iw <= w; iv <= 1'b1; fp <= f; p0 <= rnd(); p1 <= rnd(); working_register <= rnd(); pc <= rnd();
    lath <= rnd(); latu <= rnd(); return_stack_top <= rnd(); bank_select_register <= rnd(); mrd <= rnd();
    @(posedge clk);
    iv <= 1'b0;
    #1;
  endtask : op
  // two-word move; bad marks a forbidden target, ind an indirect source
  task automatic mv(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] f1, input logic bad,
                    input logic ind);
    logic [11:0] dst;
    logic        bd;   // target refused, also when a random frame lands on one
    op(w1, f1);
    chk(mra, f1 + {5'h00, w1[6:0]}, "move source");
    op(w2, rnd());
    dst = w1[7] ? fp + {5'h00, w2[6:0]} : w2[11:0];
    bd = bad || (dst == 12'hFF9) || (dst >= 12'hFFD);
    chk(mwe, !bd, "move write");
    if (!bd) chk(mwa, dst, "move target");
    if (!bd) chk(mwd, ind ? 8'h00 : mrd, "move data");
  endtask : mv
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    seed = 32'd63422; rst_n = 1'b0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; iv = 0; acc = 0;
    awa = 0; ara = 0; working_register = 0; lath = 0; fop = 0; mrd = 0; wd = 0; iw = 0; p0 = 0; p1 = 0; fp = 0;
    pc = 0; return_stack_top = 0; latu = 0; bank_select_register = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    axr(eie_pkg::OFS_CTRL); chk(got, 32'h0, "enable after reset");
    axr(eie_pkg::OFS_STAT); chk(got, 32'h1, "status after reset");
    axr(8'h0C); chk({got, resp}, {32'h0, eie_pkg::RESP_SLVERR}, "unmapped read");
    axw(8'h0C, 32'h1); chk(resp, eie_pkg::RESP_SLVERR, "unmapped write");
    // disabled: extension words only flagged
    op(16'hE805, 12'h100); chk({una, pwe, hit}, 3'b100, "disabled add");
    op(eie_pkg::OP_CALL_VIA_WORKING_OP, 12'h100); chk({una, spu, pld}, 3'b100, "disabled call");
    axw(eie_pkg::OFS_CTRL, 32'h1); chk(resp, eie_pkg::RESP_OKAY, "enable write");
    axr(eie_pkg::OFS_STAT); chk(got[8], 1'b1, "enable status");
    for (int i = 0; i < 40; i++) begin
      s = rnd() % 3; k = (i < 2) ? 6'h3F : rnd(); got = rnd();
      op({4'hE, 3'b100, got[0], s, k}, rnd());
      chk({pwe, psel, pld, hit}, {1'b1, s, 2'b01}, "pointer op");
      chk(pwd, pexp(s, k, got[0]), "pointer value");
    end
    for (int sb = 0; sb < 2; sb++) begin
      op({4'hE, 3'b100, sb[0], 2'b11, 6'h3F}, rnd());
      chk({pwe, psel, pld, spo}, 5'b11011, "frame return");
      chk({pwd, pcw}, {pexp(2'h2, 6'h3F, sb[0]), return_stack_top}, "return values");
      op(16'hE801, 12'h0); chk({pwe, hit}, 2'b00, "return second cycle");
    end
    op(16'hEAA5, 12'h1EC); chk({mwe, mwa, mwd, pwe, psel}, {1'b1, 12'h1EC, 8'hA5, 3'b110}, "push");
    chk(pwd, 12'h1EB, "push decrement");
    op(eie_pkg::OP_CALL_VIA_WORKING_OP, rnd());
    chk({spu, spd, pld, pcw}, {1'b1, pc + 21'h2, 1'b1, latu, lath, working_register}, "call");
    chk({pwe, mwe, spo}, 3'b000, "call side effects");
    op(16'hE801, 12'h0); chk({pwe, hit}, 2'b00, "call second cycle");
    mv(16'hEB05, 16'hF123, 12'h080, 1'b0, 1'b0);
    mv(16'hEB0B, 16'hF000, 12'hFE0, 1'b0, 1'b1);
    mv(16'hEB7F, 16'hFFF9, 12'hF80, 1'b1, 1'b0);
    mv(16'hEB00, 16'hFFFE, 12'h000, 1'b1, 1'b0);
    mv(16'hEB85, 16'hF07F, 12'h080, 1'b0, 1'b0);
    // 40 pointer ops, 2 returns, push, call and 5 moves ran; discarded words do not count
    axr(eie_pkg::OFS_COUNT); chk({got, resp}, {32'h00000031, eie_pkg::RESP_OKAY}, "executed count");
    // frame-relative operand window of standard instructions
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      fop <= (c == 1) ? 8'h60 : 8'h5F; acc <= (c == 2); fp <= 12'h3A0; bank_select_register <= 4'h5;
      repeat (2) @(posedge clk);
      #1;
      chk(fad, (c == 0) ? 12'h3FF : (c == 1) ? 12'hF60 : 12'h55F, "file address");
    end
    final_report();
  end
endmodule : eie_exec_tb

/* logic/eie_addr_if.sv */
// address bundle between the executor and its address unit
`timescale 1ns/1ns
interface eie_addr_if;
  logic [11:0] frame;     // frame pointer value
  logic [6:0]  src_off;   // source offset of an indexed move
  logic [11:0] src_addr;  // frame plus source offset
  logic        src_ind;   // source hits an indirect register
  logic [7:0]  fop;       // file operand of a standard op
  logic        fop_acc;   // access-bank bit of that op
  logic [3:0]  bank;      // bank select register
  logic        ext_en;    // extension enabled
  logic [11:0] file_addr; // effective file address
  logic [11:0] dst_addr;  // move destination
  logic        dst_bad;   // destination is not writable by a move
  modport unit (input frame, src_off, fop, fop_acc, bank, ext_en, dst_addr,
                output src_addr, src_ind, file_addr, dst_bad);
  modport user (output frame, src_off, fop, fop_acc, bank, ext_en, dst_addr,
                input src_addr, src_ind, file_addr, dst_bad);
endinterface : eie_addr_if

/* logic/eie_addr_unit.sv */
// address arithmetic and guards of the extended instruction executor
`timescale 1ns/1ns
module eie_addr_unit #(
  parameter logic [11:0] IND_BASE0 = 12'hFEB, // indirect window bases
  parameter logic [11:0] IND_BASE1 = 12'hFE3,
  parameter logic [11:0] IND_BASE2 = 12'hFDB,
  parameter logic [11:0] IND_SPAN  = 12'h005,
  parameter logic [11:0] PCL_ADDR  = 12'hFF9, // pc low byte
  parameter logic [11:0] STK_LOW   = 12'hFFD, // stack top bytes
  parameter logic [11:0] STK_HIGH  = 12'hFFE,
  parameter logic [11:0] STK_UPPER = 12'hFFF
) (
  eie_addr_if.unit a
);
  ////////////////////////////////////////////////////////////////
  wire        in0;  // source inside the first indirect window
  wire        in1;
  wire        in2;
  wire        idx;  // standard operand is a frame offset
  wire [11:0] acc;  // plain access-bank address
  // source wraps in the 12-bit data space, any address allowed
  assign a.src_addr = a.frame + {5'h00, a.src_off};
  assign in0 = (a.src_addr >= IND_BASE0) && (a.src_addr < IND_BASE0 + IND_SPAN);
  assign in1 = (a.src_addr >= IND_BASE1) && (a.src_addr < IND_BASE1 + IND_SPAN);
  assign in2 = (a.src_addr >= IND_BASE2) && (a.src_addr < IND_BASE2 + IND_SPAN);
  assign a.src_ind = in0 | in1 | in2;
  // pc low byte and the three stack top bytes refuse a move
  assign a.dst_bad = (a.dst_addr == PCL_ADDR) || (a.dst_addr == STK_LOW)
                  || (a.dst_addr == STK_HIGH) || (a.dst_addr == STK_UPPER);
  ////////////////////////////////////////////////////////////////
  // operand remap of the standard byte and bit instructions
  assign idx = a.ext_en && !a.fop_acc && (a.fop <= eie_pkg::IDX_LIMIT);
  assign acc = (a.fop >= eie_pkg::ACC_SPLIT) ? {eie_pkg::ACC_HI_BANK, a.fop} : {4'h0, a.fop};
  assign a.file_addr = idx ? (a.frame + {4'h0, a.fop})
                     : (a.fop_acc ? {a.bank, a.fop} : acc);
endmodule : eie_addr_unit

/* logic/eie_exec.sv */
// decode and execute unit of the extended instruction set
// Operation
// - extension inactive unless enable bit set
// - add literal to selected pointer, one cycle
// - subtract literal from selected pointer, one cycle
// - select three means frame pointer plus return
// - add to frame, then pc from stack
// - add-and-return takes two cycles, second idle
// - subtract-and-return from frame, two cycles
// - push literal at frame, then decrement frame
// - call via working pushes pc plus two
// - pc from working and both latches
// - call via working takes two cycles
// - call leaves working, status, bank untouched
// - indexed-to-file move: two words, frame source
// - file move destination from second word
// - addresses span the full data space
// - pc low, stack top never move targets
// - indirect register source moves zero
// - indexed-to-indexed move, both frame relative
// - low access operands become frame offsets
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module eie_exec #(
  parameter int AW = 8 // control bus address width
) (
  input  wire logic          clock_in,
  input  wire logic          resetn_in,
  // control bus slave
  input  wire logic [AW-1:0] s_axi_awaddr_in,
  input  wire logic          s_axi_awvalid_in,
  output wire logic          s_axi_awready_out,
  input  wire logic [31:0]   s_axi_wdata_in,
  input  wire logic [3:0]    s_axi_wstrb_in,
  input  wire logic          s_axi_wvalid_in,
  output wire logic          s_axi_wready_out,
  output wire logic [1:0]    s_axi_bresp_out,
  output wire logic          s_axi_bvalid_out,
  input  wire logic          s_axi_bready_in,
  input  wire logic [AW-1:0] s_axi_araddr_in,
  input  wire logic          s_axi_arvalid_in,
  output wire logic          s_axi_arready_out,
  output wire logic [31:0]   s_axi_rdata_out,
  output wire logic [1:0]    s_axi_rresp_out,
  output wire logic          s_axi_rvalid_out,
  input  wire logic          s_axi_rready_in,
  // core side: one instruction cycle per valid word
  input  wire logic          instr_valid_in,
  input  wire logic [15:0]   instr_word_in,
  input  wire logic [11:0]   ptr0_in,
  input  wire logic [11:0]   ptr1_in,
  input  wire logic [11:0]   frame_pointer_in,
  input  wire logic [7:0]    working_register_in,
  input  wire logic [20:0]   pc_in,
  input  wire logic [7:0]    pc_high_latch_in,
  input  wire logic [4:0]    pc_upper_latch_in,
  input  wire logic [20:0]   return_stack_top_in,
  input  wire logic [3:0]    bank_select_register_in,
  input  wire logic [7:0]    file_operand_in,
  input  wire logic          access_bit_in,
  input  wire logic [7:0]    mem_rdata_in,
  // actions, all registered
  output logic               ptr_we_out,
  output logic [1:0]         ptr_sel_out,
  output logic [11:0]        ptr_wdata_out,
  output logic               pc_load_out,
  output logic [20:0]        pc_wdata_out,
  output logic               stack_push_out,
  output logic [20:0]        stack_push_data_out,
  output logic               stack_pop_out,
  output logic [11:0]        mem_raddr_out,
  output logic               mem_we_out,
  output logic [11:0]        mem_waddr_out,
  output logic [7:0]         mem_wdata_out,
  output logic [11:0]        file_addr_out,
  output logic               ext_hit_out,
  output logic               unassigned_out
);
  ////////////////////////////////////////////////////////////////
  // state
  eie_pkg::eie_state_t st_q;      // sequencer state
  eie_pkg::eie_state_t st_d;
  logic                cfg_en_q;  // extension enable
  logic [15:0]         cnt_q;     // executed extension words
  logic                mv_idx_q;  // pending move is indexed-to-indexed
  logic                src_ind_q; // pending move source is indirect
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  eie_addr_if          au ();     // address unit bundle

  ////////////////////////////////////////////////////////////////
  // decode
  wire [15:0] w      = instr_word_in;
  wire        is_e   = (w[15:12] == eie_pkg::OP_EXT);
  wire        d_add  = is_e && (w[11:8] == eie_pkg::OP_ADD);
  wire        d_sub  = is_e && (w[11:8] == eie_pkg::OP_SUB);
  wire        d_push = is_e && (w[11:8] == eie_pkg::OP_PUSH);
  wire        d_move = is_e && (w[11:8] == eie_pkg::OP_MOVE);
  wire        d_call = (w == eie_pkg::OP_CALL_VIA_WORKING_OP);
  wire        ext_w  = d_add | d_sub | d_push | d_move | d_call;
  wire        ulnk   = (w[7:6] == eie_pkg::SEL_ULNK);
  wire        idle   = (st_q == eie_pkg::EIE_IDLE);
  wire        go     = instr_valid_in && idle;
  // extension words only execute with the enable set
  wire        run    = go && cfg_en_q && ext_w;
  wire        off    = go && !cfg_en_q && ext_w;
  wire        word2  = instr_valid_in && (st_q == eie_pkg::EIE_WORD2);
  wire        retn   = run && (d_add | d_sub) && ulnk;

  ////////////////////////////////////////////////////////////////
  // pointer arithmetic; select three always means the frame pointer
  wire [11:0] sel_ptr = (w[7:6] == 2'h0) ? ptr0_in
                      : (w[7:6] == 2'h1) ? ptr1_in : frame_pointer_in;
  wire [11:0] p_sum   = sel_ptr + {6'h00, w[5:0]};
  wire [11:0] p_diff  = sel_ptr - {6'h00, w[5:0]};
  wire [11:0] f_dec   = frame_pointer_in - eie_pkg::PUSH_STEP;

  wire        ptr_we_d   = run && (d_add | d_sub | d_push);
  wire [1:0]  ptr_sel_d  = (d_push || ulnk) ? eie_pkg::SEL_FRAME : w[7:6];
  wire [11:0] ptr_data_d = d_push ? f_dec : (d_sub ? p_diff : p_sum);
  // the returning variants reload pc from the stack top and pop it
  wire        pc_load_d  = retn || (run && d_call);
  wire [20:0] pc_data_d  = d_call ? {pc_upper_latch_in, pc_high_latch_in, working_register_in}
                         : return_stack_top_in;
  wire        pop_d      = retn;
  // call pushes the address of the word that follows it
  wire        push_d     = run && d_call;
  wire [20:0] push_dat_d = pc_in + eie_pkg::PC_STEP;

  ////////////////////////////////////////////////////////////////
  // indexed moves and the push literal store
  assign au.frame   = frame_pointer_in;
  assign au.src_off = w[6:0];
  assign au.fop     = file_operand_in;
  assign au.fop_acc = access_bit_in;
  assign au.bank    = bank_select_register_in;
  assign au.ext_en  = cfg_en_q;
  // second word holds either a 12-bit file or a 7-bit frame offset
  assign au.dst_addr = mv_idx_q ? (frame_pointer_in + {5'h00, w[6:0]})
                                : w[11:0];

  eie_addr_unit u_addr (
    .a (au.unit)
  );

  wire        mv_we   = word2 && !au.dst_bad;
  wire        mem_we_d = (run && d_push) || mv_we;
  wire [11:0] waddr_d = word2 ? au.dst_addr : frame_pointer_in;
  wire [7:0]  wdata_d = word2 ? (src_ind_q ? 8'h00 : mem_rdata_in)
                              : w[7:0];

  ////////////////////////////////////////////////////////////////
  // sequencer: second word or idle fetch cycle
  always_comb begin
    st_d = st_q;
    case (st_q)
      eie_pkg::EIE_IDLE: begin
        if (run && d_move) begin
          st_d = eie_pkg::EIE_WORD2;
        end else if (retn || (run && d_call)) begin
          st_d = eie_pkg::EIE_NOP;
        end
      end
      eie_pkg::EIE_WORD2: begin
        if (instr_valid_in) begin
          st_d = eie_pkg::EIE_IDLE;
        end
      end
      eie_pkg::EIE_NOP: begin
        // the word fetched here is discarded
        if (instr_valid_in) begin
          st_d = eie_pkg::EIE_IDLE;
        end
      end
      default: begin
        st_d = eie_pkg::EIE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      st_q <= eie_pkg::EIE_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // move context latched with the first word
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mv_idx_q  <= 1'b0;
      src_ind_q <= 1'b0;
      mem_raddr_out <= 12'h000;
    end else if (run && d_move) begin
      mv_idx_q  <= w[7];
      src_ind_q <= au.src_ind;
      mem_raddr_out <= au.src_addr;
    end
  end

  ////////////////////////////////////////////////////////////////
  // core-side action registers; no working, status or bank writes
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ptr_we_out          <= 1'b0;
      ptr_sel_out         <= 2'h0;
      ptr_wdata_out       <= 12'h000;
      pc_load_out         <= 1'b0;
      pc_wdata_out        <= 21'h000000;
      stack_push_out      <= 1'b0;
      stack_push_data_out <= 21'h000000;
      stack_pop_out       <= 1'b0;
    end else begin
      ptr_we_out          <= ptr_we_d;
      ptr_sel_out         <= ptr_sel_d;
      ptr_wdata_out       <= ptr_data_d;
      pc_load_out         <= pc_load_d;
      pc_wdata_out        <= pc_data_d;
      stack_push_out      <= push_d;
      stack_push_data_out <= push_dat_d;
      stack_pop_out       <= pop_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mem_we_out     <= 1'b0;
      mem_waddr_out  <= 12'h000;
      mem_wdata_out  <= 8'h00;
      file_addr_out  <= 12'h000;
      ext_hit_out    <= 1'b0;
      unassigned_out <= 1'b0;
    end else begin
      mem_we_out     <= mem_we_d;
      mem_waddr_out  <= waddr_d;
      mem_wdata_out  <= wdata_d;
      file_addr_out  <= au.file_addr;
      ext_hit_out    <= run;
      unassigned_out <= off;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control bus: write waits for address and data together
  wire       wr_go  = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
  wire       rd_go  = s_axi_arvalid_in && !rvalid_q;
  wire [7:0] wa     = s_axi_awaddr_in[7:0];
  wire [7:0] ra     = s_axi_araddr_in[7:0];
  wire       wa_ok  = (wa == eie_pkg::OFS_CTRL) || (wa == eie_pkg::OFS_STAT)
                   || (wa == eie_pkg::OFS_COUNT);
  wire       ra_ok  = (ra == eie_pkg::OFS_CTRL) || (ra == eie_pkg::OFS_STAT)
                   || (ra == eie_pkg::OFS_COUNT);
  wire [31:0] rd_mux = (ra == eie_pkg::OFS_CTRL) ? {31'h00000000, cfg_en_q}
                     : (ra == eie_pkg::OFS_STAT) ? {23'h000000, cfg_en_q, 5'h00, st_q}
                     : (ra == eie_pkg::OFS_COUNT) ? {16'h0000, cnt_q} : 32'h00000000;

  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out  = wr_go;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = rd_go;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  // enable bit; only lane zero carries it
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cfg_en_q <= eie_pkg::CTRL_EN_RST;
    end else if (wr_go && (wa == eie_pkg::OFS_CTRL) && s_axi_wstrb_in[0]) begin
      cfg_en_q <= s_axi_wdata_in[eie_pkg::CTRL_EN_BIT];
    end
  end

  // executed extension words, wraps
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt_q <= 16'h0000;
    end else if (run) begin
      cnt_q <= cnt_q + eie_pkg::CNT_STEP;
    end
  end

  // write response; unmapped offsets answer slave error
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= eie_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wa_ok ? eie_pkg::RESP_OKAY : eie_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= eie_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= ra_ok ? eie_pkg::RESP_OKAY : eie_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  chk_disabled_quiet: assert property (
    (go && !cfg_en_q && ext_w) |=> (unassigned_out && !ptr_we_out && !mem_we_out && !pc_load_out)
  ) else $error("disabled extension word acted");

  chk_add_ptr: assert property (
    (run && d_add && !ulnk) |=> (ptr_we_out && !pc_load_out && ptr_sel_out == $past(w[7:6])
      && ptr_wdata_out == $past(sel_ptr) + {6'h00, $past(w[5:0])})
  ) else $error("pointer add wrong");

  chk_sub_ptr: assert property (
    (run && d_sub && !ulnk) |=> (ptr_we_out && ptr_wdata_out == $past(sel_ptr) - {6'h00, $past(w[5:0])})
  ) else $error("pointer subtract wrong");

  chk_ret_frame: assert property (
    (run && (d_add | d_sub) && ulnk) |=> (ptr_sel_out == 2'h2 && stack_pop_out && pc_load_out
      && pc_wdata_out == $past(return_stack_top_in))
  ) else $error("returning variant wrong");

  chk_ret_two: assert property (
    (run && d_add && ulnk) |=> (st_q == eie_pkg::EIE_NOP) ##1 (!pc_load_out && !ptr_we_out)
  ) else $error("add-and-return second cycle not idle");

  chk_push_lit: assert property (
    (run && d_push) |=> (mem_we_out && mem_waddr_out == $past(frame_pointer_in)
      && mem_wdata_out == $past(w[7:0]) && ptr_wdata_out == $past(frame_pointer_in) - 12'h001)
  ) else $error("push literal wrong");

  chk_call_w: assert property (
    (run && d_call) |=> (stack_push_out && stack_push_data_out == $past(pc_in) + 21'h000002
      && pc_wdata_out[7:0] == $past(working_register_in)) ##1 !pc_load_out
  ) else $error("call via working wrong");

  chk_move_zero: assert property (
    (word2 && src_ind_q && !au.dst_bad) |=> (mem_we_out && mem_wdata_out == 8'h00)
  ) else $error("indirect source not zero");

  chk_dest_guard: assert property (
    (word2 && au.dst_bad) |=> !mem_we_out
  ) else $error("forbidden move target written");

  chk_index_map: assert property (
    (cfg_en_q && !access_bit_in && file_operand_in <= 8'h5F)
      |=> file_addr_out == $past(frame_pointer_in) + {4'h0, $past(file_operand_in)}
  ) else $error("offset operand not frame relative");
endmodule : eie_exec

/* logic/eie_pkg.sv */
// shared constants and types for the extended instruction executor
package eie_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STAT    = 8'h04;
  localparam logic [7:0]  OFS_COUNT   = 8'h08;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // opcode fields
  localparam logic [3:0]  OP_EXT      = 4'hE;
  localparam logic [3:0]  OP_ADD      = 4'h8;
  localparam logic [3:0]  OP_SUB      = 4'h9;
  localparam logic [3:0]  OP_PUSH     = 4'hA;
  localparam logic [3:0]  OP_MOVE     = 4'hB;
  localparam logic [3:0]  OP_WORD2    = 4'hF;
  localparam logic [15:0] OP_CALL_VIA_WORKING_OP    = 16'h0014;
  localparam logic [1:0]  SEL_FRAME   = 2'h2;
  localparam logic [1:0]  SEL_ULNK    = 2'h3;
  // indexed literal offset window of the standard instructions
  localparam logic [7:0]  IDX_LIMIT   = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [11:0] PUSH_STEP   = 12'h001;
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  // sequencer states
  typedef enum logic [2:0] {
    EIE_IDLE  = 3'b001,
    EIE_WORD2 = 3'b010,
    EIE_NOP   = 3'b100
  } eie_state_t;
endpackage : eie_pkg
